// *** rtl/ppc_crossbar_io.sv ***
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module ppc_crossbar_io (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic resetn,
	// Avalon-MM register slave.
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Peripheral side.
	input wire ppc_pkg::ppc_sig_t periphDrv,
	input wire logic uart0Mode0,
	input wire logic uart1Mode0,
	output logic [27:0] periphIn,
	// Pads, ports 0 to 3 flattened, port 0 pin 0 at bit 0.
	input wire logic [31:0] padIn,
	output var ppc_pkg::ppc_pad_t padDrv
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] cfgA;
		logic [7:0] cfgB;
		logic [7:0] cfgC;
		logic [7:0] p1InMode;
		logic [31:0] latch;
		logic [31:0] mode;
		logic waitReq;
		logic [31:0] readData;
		logic [27:0] periphIn;
		ppc_pkg::ppc_pad_t pad;
	} ppc_state_t;

	ppc_state_t r;
	ppc_state_t n;
	logic [31:0] padLevel;
	logic [31:0] skip;
	logic [31:0] pinRead;
	logic [27:0] en;
	ppc_pkg::ppc_map_t map;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Picks byte lane idx of a port-wide vector.
	function automatic logic [7:0] byteOf(input logic [31:0] v,
		input logic [1:0] idx);
		byteOf = v[{idx, 3'b000} +: 8];
	endfunction

	// True when the address falls in a four-word bank.
	function automatic logic inBank(input logic [6:0] a,
		input logic [6:0] base);
		inBank = (a[6:4] == base[6:4]) && (a[1:0] == 2'h0);
	endfunction

	// Turns the configuration bits into one enable per signal slot.
	function automatic logic [27:0] slotEnables(input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] c);
		logic [27:0] e;
		e = '0;
		e[1:0] = {2{a[ppc_pkg::CA_UART0]}};
		e[5:2] = {4{a[ppc_pkg::CA_SPI]}};
		e[7:6] = {2{a[ppc_pkg::CA_SMB]}};
		e[9:8] = {2{c[ppc_pkg::CC_UART1]}};
		for (int k = 0; k < ppc_pkg::CEX_MAX; k++) begin
			e[ppc_pkg::SIG_COUNTER_ARRAY_OUT_A + k] =
				a[ppc_pkg::CA_CEX_LO +: 3] > 3'(k);
		end
		e[ppc_pkg::SIG_ECI] = a[ppc_pkg::CA_ECI];
		e[ppc_pkg::SIG_CP0] = a[ppc_pkg::CA_CP0];
		e[ppc_pkg::SIG_CP1] = b[ppc_pkg::CB_CP1];
		e[ppc_pkg::SIG_T0 +: 6] = {b[ppc_pkg::CB_TIMER_TWO_TRIGGER],
			b[ppc_pkg::CB_T2], b[ppc_pkg::CB_EXT_IRQ_B_PIN], b[ppc_pkg::CB_T1],
			b[ppc_pkg::CB_EXT_IRQ_A_PIN], b[ppc_pkg::CB_T0]};
		e[25:24] = {c[ppc_pkg::CC_TIMER_FOUR_TRIGGER], c[ppc_pkg::CC_T4]};
		e[ppc_pkg::SIG_SYSCK] = b[ppc_pkg::CB_SYSCK];
		e[ppc_pkg::SIG_CNV] = c[ppc_pkg::CC_CNV];
		slotEnables = e;
	endfunction

	// Packs enabled slots onto free pins, lowest slot first.
	function automatic ppc_pkg::ppc_map_t allocate(input logic [27:0] e,
		input logic [31:0] sk);
		ppc_pkg::ppc_map_t m;
		logic [27:0] rem;
		logic found;
		m = '0;
		rem = e;
		for (int p = 0; p < ppc_pkg::NPIN; p++) begin
			found = 1'b0;
			for (int s = 0; s < ppc_pkg::NSIG; s++) begin
				if (!sk[p] && rem[s] && !found) begin
					m.used[p] = 1'b1;
					m.sig[p] = 5'(s);
					rem[s] = 1'b0;
					found = 1'b1;
				end
			end
		end
		allocate = m;
	endfunction

	// ----------------------------------------------------------------
	// Pad synchroniser
	// ----------------------------------------------------------------
	ppc_pin_sync u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.padIn(padIn),
		.padLevel(padLevel)
	);

	// Allocation map; disabled slots never reach a pin.
	always_comb begin
		en = slotEnables(r.cfgA, r.cfgB, r.cfgC);
		skip = '0;
		skip[ppc_pkg::P1_BASE +: 8] = ~r.p1InMode;
		map = allocate(en, skip);
		pinRead = padLevel & ~skip;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [4:0] s;
		logic val;
		logic drv;
		logic od;
		logic rxOut;
		n = r;
		s = '0;
		val = 1'b0;
		drv = 1'b0;
		od = 1'b0;
		rxOut = 1'b0;
		// Pin drivers.
		for (int p = 0; p < ppc_pkg::NPIN; p++) begin
			s = map.sig[p];
			rxOut = (s == 5'(ppc_pkg::SIG_RX0) && uart0Mode0) ||
				(s == 5'(ppc_pkg::SIG_RX1) && uart1Mode0);
			if (map.used[p]) begin
				val = periphDrv.value[s];
				drv = periphDrv.drive[s] &&
					(!ppc_pkg::SIG_INPUT[s] || rxOut);
				od = ppc_pkg::SIG_FORCE_OD[s] || rxOut ||
					!r.mode[p];
			end else begin
				val = r.latch[p];
				drv = 1'b1;
				od = !r.mode[p];
			end
			n.pad.level[p] = val;
			// Push-pull drives both ways, open-drain only low.
			n.pad.oeN[p] = !(r.cfgC[ppc_pkg::CC_CROSSBAR_GLOBAL_ENABLE] && drv &&
				(!od || !val));
		end
		// Peripheral inputs idle high when their slot has no pin.
		n.periphIn = '1;
		for (int p = 0; p < ppc_pkg::NPIN; p++) begin
			if (map.used[p]) begin
				n.periphIn[map.sig[p]] = padLevel[p];
			end
		end
		// Bus: answer one cycle after the request, commit on release.
		if (r.waitReq) begin
			if (avs_read || avs_write) begin
				n.waitReq = 1'b0;
			end
			if (avs_read) begin
				n.readData = '0;
				if (inBank(avs_address, ppc_pkg::OFS_PORT)) begin
					n.readData[7:0] =
						byteOf(pinRead, avs_address[3:2]);
				end else if (inBank(avs_address, ppc_pkg::OFS_MODE)) begin
					n.readData[7:0] = byteOf(r.mode, avs_address[3:2]);
				end else if (inBank(avs_address, ppc_pkg::OFS_RMW)) begin
					n.readData[7:0] =
						byteOf(r.latch, avs_address[3:2]);
				end else if (avs_address == ppc_pkg::OFS_CFG_A) begin
					n.readData[7:0] = r.cfgA;
				end else if (avs_address == ppc_pkg::OFS_CFG_B) begin
					n.readData[7:0] = r.cfgB;
				end else if (avs_address == ppc_pkg::OFS_CFG_C) begin
					n.readData[7:0] = r.cfgC;
				end else if (avs_address == ppc_pkg::OFS_P1_IN) begin
					n.readData[7:0] = r.p1InMode;
				end
			end
		end else begin
			n.waitReq = 1'b1;
			if (avs_write && avs_byteenable[0]) begin
				if (inBank(avs_address, ppc_pkg::OFS_PORT) ||
					inBank(avs_address, ppc_pkg::OFS_RMW)) begin
					n.latch[{avs_address[3:2], 3'b000} +: 8] =
						avs_writedata[7:0];
				end else if (inBank(avs_address, ppc_pkg::OFS_MODE)) begin
					n.mode[{avs_address[3:2], 3'b000} +: 8] =
						avs_writedata[7:0];
				end else if (avs_address == ppc_pkg::OFS_CFG_A) begin
					n.cfgA = avs_writedata[7:0];
				end else if (avs_address == ppc_pkg::OFS_CFG_B) begin
					n.cfgB = avs_writedata[7:0];
				end else if (avs_address == ppc_pkg::OFS_CFG_C) begin
					n.cfgC = avs_writedata[7:0];
				end else if (avs_address == ppc_pkg::OFS_P1_IN) begin
					n.p1InMode = avs_writedata[7:0];
				end else if (avs_address == ppc_pkg::OFS_BITOP) begin
					n.latch[avs_writedata[4:0]] =
						avs_writedata[ppc_pkg::BITOP_VAL];
				end
			end
		end
	end

	// Registers; every enable resets clear, so no pin is driven.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			r.cfgA <= ppc_pkg::CFG_RST;
			r.cfgB <= ppc_pkg::CFG_RST;
			r.cfgC <= ppc_pkg::CFG_RST;
			r.p1InMode <= ppc_pkg::P1IN_RST;
			r.latch <= ppc_pkg::LATCH_RST;
			r.mode <= ppc_pkg::MODE_RST;
			r.waitReq <= 1'b1;
			r.readData <= '0;
			r.periphIn <= '1;
			r.pad <= {32'hffffffff, 32'hffffffff};
		end else begin
			r <= n;
		end
	end

	assign avs_readdata = r.readData;
	assign avs_waitrequest = r.waitReq;
	assign periphIn = r.periphIn;
	assign padDrv = r.pad;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_crossbar_global_enable_off;
		@(posedge sys_clk) disable iff (!resetn)
		!r.cfgC[ppc_pkg::CC_CROSSBAR_GLOBAL_ENABLE] |=> (padDrv.oeN == 32'hffffffff);
	endproperty
	a_crossbar_global_enable_off: assert property (p_crossbar_global_enable_off)
		else $error("Pad driven while crossbar disabled.");

	property p_uart_pair;
		@(posedge sys_clk) disable iff (!resetn)
		r.cfgA[ppc_pkg::CA_UART0] |-> map.used[0] && map.used[1] &&
			map.sig[1] == 5'h01;
	endproperty
	a_uart_pair: assert property (p_uart_pair)
		else $error("Primary UART pins not packed together.");

	property p_tx_follow;
		@(posedge sys_clk) disable iff (!resetn)
		r.cfgA[ppc_pkg::CA_UART0] && r.cfgC[ppc_pkg::CC_CROSSBAR_GLOBAL_ENABLE] &&
			r.mode[0] && periphDrv.drive[ppc_pkg::SIG_TX0]
		|=> !padDrv.oeN[0] &&
			padDrv.level[0] == $past(periphDrv.value[ppc_pkg::SIG_TX0]);
	endproperty
	a_tx_follow: assert property (p_tx_follow)
		else $error("Allocated pin does not follow its peripheral.");

	property p_rx_input;
		@(posedge sys_clk) disable iff (!resetn)
		r.cfgA[ppc_pkg::CA_UART0] && !uart0Mode0 |=> padDrv.oeN[1];
	endproperty
	a_rx_input: assert property (p_rx_input)
		else $error("Receive pin driven.");

	property p_gpio_pp;
		@(posedge sys_clk) disable iff (!resetn)
		!map.used[31] && r.cfgC[ppc_pkg::CC_CROSSBAR_GLOBAL_ENABLE] && r.mode[31]
		|=> !padDrv.oeN[31] && padDrv.level[31] == $past(r.latch[31]);
	endproperty
	a_gpio_pp: assert property (p_gpio_pp)
		else $error("Push-pull pin not driving latch value.");

	property p_gpio_od;
		@(posedge sys_clk) disable iff (!resetn)
		!map.used[31] && !r.mode[31] && r.latch[31] |=> padDrv.oeN[31];
	endproperty
	a_gpio_od: assert property (p_gpio_od)
		else $error("Open-drain pin driven high.");

	property p_sda_od;
		@(posedge sys_clk) disable iff (!resetn)
		map.used[6] && map.sig[6] == 5'h06 &&
			periphDrv.value[ppc_pkg::SIG_SDA] |=> padDrv.oeN[6];
	endproperty
	a_sda_od: assert property (p_sda_od)
		else $error("Data line driven high.");

	property p_pin_read;
		@(posedge sys_clk) disable iff (!resetn)
		r.waitReq && avs_read && avs_address == ppc_pkg::OFS_PORT
		|=> !avs_waitrequest && avs_readdata[7:0] == $past(pinRead[7:0]);
	endproperty
	a_pin_read: assert property (p_pin_read)
		else $error("Port read did not return pin levels.");

	property p_rmw_read;
		@(posedge sys_clk) disable iff (!resetn)
		r.waitReq && avs_read && avs_address == ppc_pkg::OFS_RMW
		|=> avs_readdata[7:0] == $past(r.latch[7:0]) ##1 avs_waitrequest;
	endproperty
	a_rmw_read: assert property (p_rmw_read)
		else $error("Read-modify-write read did not return latch.");
endmodule
`default_nettype wire

// *** pkg/ppc_pkg.sv ***
`default_nettype none
package ppc_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NPIN = 32;
	localparam int NSIG = 28;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [6:0] OFS_PORT = 7'h00;
	localparam logic [6:0] OFS_MODE = 7'h10;
	localparam logic [6:0] OFS_CFG_A = 7'h20;
	localparam logic [6:0] OFS_CFG_B = 7'h24;
	localparam logic [6:0] OFS_CFG_C = 7'h28;
	localparam logic [6:0] OFS_P1_IN = 7'h2c;
	localparam logic [6:0] OFS_RMW = 7'h30;
	localparam logic [6:0] OFS_BITOP = 7'h40;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CA_SMB = 0;
	localparam int CA_SPI = 1;
	localparam int CA_UART0 = 2;
	localparam int CA_CEX_LO = 3;
	localparam int CA_ECI = 6;
	localparam int CA_CP0 = 7;
	localparam int CB_CP1 = 0;
	localparam int CB_T0 = 1;
	localparam int CB_EXT_IRQ_A_PIN = 2;
	localparam int CB_T1 = 3;
	localparam int CB_EXT_IRQ_B_PIN = 4;
	localparam int CB_T2 = 5;
	localparam int CB_TIMER_TWO_TRIGGER = 6;
	localparam int CB_SYSCK = 7;
	localparam int CC_CNV = 0;
	localparam int CC_UART1 = 2;
	localparam int CC_T4 = 3;
	localparam int CC_TIMER_FOUR_TRIGGER = 4;
	localparam int CC_CROSSBAR_GLOBAL_ENABLE = 6;
	localparam int BITOP_VAL = 8;
	localparam int P1_BASE = 8;
	localparam int CEX_MAX = 5;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] P1IN_RST = 8'hff;
	localparam logic [31:0] LATCH_RST = 32'hffffffff;
	localparam logic [31:0] MODE_RST = 32'h00000000;

	// ----------------------------------------------------------------
	// Peripheral signal slots, in priority order
	// ----------------------------------------------------------------
	localparam int SIG_TX0 = 0;
	localparam int SIG_RX0 = 1;
	localparam int SIG_SDA = 6;
	localparam int SIG_SCL = 7;
	localparam int SIG_RX1 = 9;
	localparam int SIG_COUNTER_ARRAY_OUT_A = 10;
	localparam int SIG_ECI = 15;
	localparam int SIG_CP0 = 16;
	localparam int SIG_CP1 = 17;
	localparam int SIG_T0 = 18;
	localparam int SIG_SYSCK = 26;
	localparam int SIG_CNV = 27;
	// Slots that are inputs to their peripheral.
	localparam logic [27:0] SIG_INPUT = 28'h0bfc8202;
	// Slots that are always open-drain.
	localparam logic [27:0] SIG_FORCE_OD = 28'h00000c0;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [27:0] value;
		logic [27:0] drive;
	} ppc_sig_t;

	typedef struct packed {
		logic [31:0] level;
		logic [31:0] oeN;
	} ppc_pad_t;

	typedef struct packed {
		logic [31:0] used;
		logic [31:0][4:0] sig;
	} ppc_map_t;
endpackage
`default_nettype wire

// *** rtl/ppc_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_sync (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic resetn,
	// Raw pad levels and their synchronised copy.
	input wire logic [31:0] padIn,
	output logic [31:0] padLevel
);
	typedef struct packed {
		logic [31:0] s1;
		logic [31:0] s2;
	} ppc_sync_t;

	ppc_sync_t r;
	ppc_sync_t n;

	// Two flops; only the second stage is seen outside.
	always_comb begin
		n = r;
		n.s1 = padIn;
		n.s2 = r.s1;
	end

	// Pads idle high through the pull-ups, so reset to ones.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			r <= {32'hffffffff, 32'hffffffff};
		end else begin
			r <= n;
		end
	end

	assign padLevel = r.s2;
endmodule
`default_nettype wire

// *** testbench/ppc_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppc_board (
	// Pad drive from the block.
	input wire ppc_pkg::ppc_pad_t padDrv,
	// Pins that external parts pull low.
	input wire logic [31:0] extLow,
	// Resolved pin levels.
	output logic [31:0] padIn
);
	// A driven pad shows its level, a released one is pulled up unless sunk.
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			padIn[i] = padDrv.oeN[i] ? ~extLow[i] : padDrv.level[i];
		end
	end
endmodule
`default_nettype wire

// *** testbench/priority_pin_crossbar_port_io_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin \
	mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module priority_pin_crossbar_port_io_test;
	// ----------------------------------------------------------------
	// Stimulus and observation
	// ----------------------------------------------------------------
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [6:0] avs_address = 7'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	wire logic [31:0] avs_readdata;
	wire logic avs_waitrequest;
	ppc_pkg::ppc_sig_t periphDrv = 56'h0;
	logic uart0Mode0 = 1'b0;
	logic uart1Mode0 = 1'b0;
	logic [31:0] extLow = 32'h0;
	wire logic [27:0] periphIn;
	wire logic [31:0] padIn;
	ppc_pkg::ppc_pad_t padDrv;
	int mismatches = 0;
	int checksDone = 0;
	int cycles = 0;
	logic [31:0] rdv;

	ppc_crossbar_io dut_u (.sys_clk(sys_clk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .periphDrv(periphDrv),
		.uart0Mode0(uart0Mode0), .uart1Mode0(uart1Mode0),
		.periphIn(periphIn), .padIn(padIn), .padDrv(padDrv));
	ppc_board board_u (.padDrv(padDrv), .extLow(extLow), .padIn(padIn));

	// The clock toggles every half period of 20 ns.
	always #20 sys_clk = ~sys_clk;

	// A hung run is cut short and counted as a mismatch.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			wrapUp();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic wrapUp;
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One bus access, held until waitrequest is sampled low.
	// Only the run timeout ends a wait that never answers.
	task automatic busGo(input logic [6:0] a, input logic w,
		input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'h1;
		avs_write <= w;
		avs_read <= ~w;
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		rdv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// Reads a register and compares it.
	task automatic chkRd(input logic [6:0] a, input logic [31:0] e);
		busGo(a, 1'b0, 32'h0);
		`CHK("readdata", e, rdv)
	endtask

	// Lets register, pad and synchroniser stages settle.
	task automatic settle;
		repeat (5) @(posedge sys_clk);
	endtask

	// Programs the crossbar with the global enable off, then on.
	task automatic setXbar(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c);
		busGo(7'h28, 1'b1, 32'h0);
		busGo(7'h20, 1'b1, {24'h0, a});
		busGo(7'h24, 1'b1, {24'h0, b});
		busGo(7'h28, 1'b1, {24'h0, c});
		settle();
	endtask

	// Reset values of configuration, mode and latch registers.
	task automatic tResetVals;
		`CHK("oeN", 32'hffffffff, padDrv.oeN)
		chkRd(7'h20, 32'h0);
		chkRd(7'h24, 32'h0);
		chkRd(7'h28, 32'h0);
		for (int i = 0; i < 4; i++)
			chkRd(7'(7'h10 + 4 * i), 32'h0);
		chkRd(7'h30, 32'hff);
		chkRd(7'h2c, 32'hff);
		chkRd(7'h50, 32'h0);
	endtask

	// GPIO on port 0 before and after the global enable.
	task automatic tGpio;
		busGo(7'h00, 1'b1, 32'h5a);
		busGo(7'h10, 1'b1, 32'hff);
		settle();
		`CHK("oeN off", 8'hff, padDrv.oeN[7:0])
		busGo(7'h28, 1'b1, 32'h40);
		settle();
		`CHK("oeN pp", 8'h00, padDrv.oeN[7:0])
		`CHK("level pp", 8'h5a, padDrv.level[7:0])
		busGo(7'h10, 1'b1, 32'h00);
		settle();
		`CHK("oeN od", 8'h5a, padDrv.oeN[7:0])
		chkRd(7'h00, 32'h5a);
		extLow <= 32'h2;
		settle();
		chkRd(7'h00, 32'h58);
		chkRd(7'h30, 32'h5a);
		busGo(7'h40, 1'b1, 32'h100);
		chkRd(7'h30, 32'h5b);
		extLow <= 32'h0;
	endtask

	// Primary UART pins against latch and mode settings.
	task automatic tUart;
		busGo(7'h00, 1'b1, 32'h00);
		busGo(7'h10, 1'b1, 32'hff);
		periphDrv.value[0] <= 1'b1;
		periphDrv.drive[0] <= 1'b1;
		setXbar(8'h04, 8'h00, 8'h40);
		`CHK("tx oeN", 1'b0, padDrv.oeN[0])
		`CHK("tx level", 1'b1, padDrv.level[0])
		`CHK("rx oeN", 1'b1, padDrv.oeN[1])
		periphDrv.value[0] <= 1'b0;
		busGo(7'h00, 1'b1, 32'hfd);
		extLow <= 32'h2;
		settle();
		`CHK("tx level", 1'b0, padDrv.level[0])
		`CHK("rx in", 1'b0, periphIn[1])
		chkRd(7'h00, 32'hfc);
		extLow <= 32'h0;
	endtask

	// Packing of enabled peripherals on port 0.
	task automatic tPack;
		logic [7:0] ta [6] = '{8'h14, 8'h14, 8'h3c, 8'h00, 8'h00, 8'h04};
		logic [7:0] tb [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h02};
		logic [7:0] tc [6] = '{8'h40, 8'h44, 8'h40, 8'h40, 8'h40, 8'h40};
		logic [7:0] eo [6] = '{8'h02, 8'h0a, 8'h02, 8'h00, 8'h00, 8'h06};
		logic [7:0] ed [6] = '{8'h0d, 8'h35, 8'h7d, 8'h00, 8'h01, 8'h01};
		for (int i = 0; i < 4; i++) begin
			busGo(7'(4 * i), 1'b1, 32'h00);
			busGo(7'(7'h10 + 4 * i), 1'b1, 32'hff);
		end
		periphDrv.value <= 28'hfffffff;
		periphDrv.drive <= ~ppc_pkg::SIG_INPUT;
		for (int i = 0; i < 6; i++) begin
			setXbar(ta[i], tb[i], tc[i]);
			`CHK("pack oeN", eo[i], padDrv.oeN[7:0])
			`CHK("pack drv", ed[i], padDrv.level[7:0] & ~eo[i])
		end
	endtask

	// Analog port 1 pins are passed over.
	task automatic tAnalog;
		setXbar(8'hfc, 8'h00, 8'h40);
		`CHK("eci cp0", 3'b001, padDrv.oeN[9:7])
		`CHK("cp0 p8", 2'b01, padDrv.level[9:8])
		busGo(7'h2c, 1'b1, 32'hfe);
		settle();
		`CHK("cp0 p9", 2'b10, padDrv.level[9:8])
		busGo(7'h2c, 1'b1, 32'hff);
	endtask

	// Bus and mode-0 receive pins stay open-drain in push-pull mode.
	task automatic tForceOd;
		setXbar(8'h07, 8'h00, 8'h40);
		`CHK("smb high", 2'b11, padDrv.oeN[7:6])
		periphDrv.value[6] <= 1'b0;
		settle();
		`CHK("sda low", 2'b00, {padDrv.oeN[6], padDrv.level[6]})
		periphDrv.drive[1] <= 1'b1;
		uart0Mode0 <= 1'b1;
		setXbar(8'h04, 8'h00, 8'h40);
		`CHK("rx m0 high", 1'b1, padDrv.oeN[1])
		periphDrv.value[1] <= 1'b0;
		settle();
		`CHK("rx m0 low", 1'b0, padDrv.oeN[1])
		uart0Mode0 <= 1'b0;
		settle();
		`CHK("rx input", 1'b1, padDrv.oeN[1])
		periphDrv.drive[9] <= 1'b1;
		uart1Mode0 <= 1'b1;
		setXbar(8'h04, 8'h00, 8'h44);
		`CHK("rx1 m0 high", 1'b1, padDrv.oeN[3])
		periphDrv.value[9] <= 1'b0;
		settle();
		`CHK("rx1 m0 low", 2'b00, {padDrv.oeN[3], padDrv.level[3]})
		uart1Mode0 <= 1'b0;
		settle();
		`CHK("rx1 input", 1'b1, padDrv.oeN[3])
	endtask

	// Main sequence: reset for eight cycles, then each scenario.
	initial begin
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		tResetVals();
		tGpio();
		tUart();
		tPack();
		tAnalog();
		tForceOd();
		wrapUp();
	end
endmodule
`default_nettype wire
